// *** mol_defines.svh ***
/*
  Constants of the motion override block: register offsets, field positions,
  command codes, reset values and timing.
  Assumes a 100 MHz system clock and one aligned 32-bit word per register.
*/
`ifndef MOL_DEFINES_SVH
`define MOL_DEFINES_SVH
`define MOL_OFS_CTRL 12'h000
`define MOL_OFS_INIT_VEL 12'h004
`define MOL_OFS_PEAK_VEL 12'h008
`define MOL_OFS_ACC_TIME 12'h00c
`define MOL_OFS_DEC_TIME 12'h010
`define MOL_OFS_MOVE_ARG 12'h014
`define MOL_OFS_REQ_VEL 12'h018
`define MOL_OFS_REQ_TIME 12'h01c
`define MOL_OFS_REQ_TARGET 12'h020
`define MOL_OFS_RANGE 12'h024
`define MOL_OFS_CMD 12'h028
`define MOL_OFS_STATUS 12'h02c
`define MOL_OFS_ERR 12'h030
`define MOL_OFS_POSITION 12'h034
`define MOL_OFS_CUR_VEL 12'h038
`define MOL_OFS_AXIS_ID 12'h03c
`define MOL_CTRL_SCURVE 0
`define MOL_CTRL_LINKED 1
`define MOL_ERR_SINGLE 0
`define MOL_ERR_MODE 1
`define MOL_ERR_PULSES 2
`define MOL_ERR_DECEL 3
`define MOL_ERR_NEAR 4
`define MOL_ERR_BUSY 5
`define MOL_AXIS_OK_BIT 7
`define MOL_CMD_START_VEL 4'h1
`define MOL_CMD_START_REL 4'h2
`define MOL_CMD_START_ABS 4'h3
`define MOL_CMD_V_CHANGE 4'h4
`define MOL_CMD_CMP_V_CHANGE 4'h5
`define MOL_CMD_P_CHANGE 4'h6
`define MOL_CMD_RAMP_STOP 4'h7
`define MOL_CMD_EMG_STOP 4'h8
`define MOL_CMD_FIX_RANGE 4'h9
`define MOL_CMD_UNFIX_RANGE 4'ha
`define MOL_RST_INIT_VEL 32'h0000_0000
`define MOL_RST_PEAK_VEL 32'h0000_1000
`define MOL_RST_ACC_TIME 24'h0003e8
`define MOL_RST_DEC_TIME 24'h0003e8
`define MOL_RST_RANGE 32'h0001_0000
`define MOL_VEL_MAX 32'h0001_0000
`define MOL_VEL_CREEP 32'h0000_0100
`define MOL_BOARD_MAX 4'hc
`define MOL_DIV_STEPS 6'h20
`define MOL_CLK_NS 10
`define MOL_TICK_NS 1000
`define MOL_TICK_CYCLES ((`MOL_TICK_NS + `MOL_CLK_NS - 1) / `MOL_CLK_NS)
`endif

// *** mol_pkg.sv ***
/*
  Types of the motion override block: phases, move modes and state records.
  Assumes mol_defines.svh supplies every number.
*/
package mol_pkg;
  typedef enum logic [2:0] {MOL_IDLE, MOL_SOLVE, MOL_RAMP, MOL_CRUISE, MOL_DECEL} mol_phase_t;
  typedef enum logic [1:0] {MOL_MODE_VEL, MOL_MODE_REL, MOL_MODE_ABS} mol_mode_t;
  typedef struct packed {
    logic busy;
    logic done;
    logic [5:0] cnt;
    logic [24:0] rem;
    logic [31:0] quo;
  } mol_div_st_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic scurve;
    logic linked;
    logic [31:0] init_vel, peak_cfg, move_arg, req_vel, req_tgt, range;
    logic [23:0] acc_t, dec_t, req_t;
    logic range_fixed;
    mol_phase_t phase;
    mol_phase_t after;
    mol_mode_t mode;
    logic stopping, dir, cmp_armed, cmp_prev, pulse;
    logic [31:0] pos, target, vel, vgoal, rate, peak, start_peak;
    logic [15:0] frac;
    logic [15:0] tick_cnt;
    logic div_go;
    logic [31:0] div_num;
    logic [23:0] div_den;
    logic [5:0] err;
    logic [3:0] board;
    logic board_taken;
  } mol_axis_st_t;
endpackage

// *** mol_div.sv ***
/*
  Restoring divider, one quotient bit per clock, used to turn a speed step
  and a transition time into a per-tick velocity increment.
  Assumes start is a one-cycle pulse and the divisor is not zero.
*/
`timescale 1ns/1ps
`include "mol_defines.svh"
module mol_div import mol_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [31:0] dividend,
  input wire logic [23:0] divisor,
  output logic done,
  output logic [31:0] quotient
);
  mol_div_st_t st_ff, nxt_st;
  logic [24:0] shifted;

  assign shifted = {st_ff.rem[23:0], st_ff.quo[31]};
  assign done = st_ff.done;
  assign quotient = st_ff.quo;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    if (start) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt = `MOL_DIV_STEPS;
      nxt_st.rem = 25'h0;
      nxt_st.quo = dividend;
    end else if (st_ff.busy) begin
      nxt_st.quo = {st_ff.quo[30:0], 1'b0};
      if (shifted >= {1'b0, divisor}) begin
        nxt_st.rem = shifted - {1'b0, divisor};
        nxt_st.quo[0] = 1'b1;
      end else begin
        nxt_st.rem = shifted;
      end
      nxt_st.cnt = st_ff.cnt - 6'h1;
      if (st_ff.cnt == 6'h1) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// *** mol_axis.sv ***
/*
  One axis of pulse-train motion with on-the-fly speed and target override,
  an APB register slave and global axis numbering.
  Assumes APB inputs synchronous to clk and a board switch that is static.
*/
// The APB slave port and the placing of the registers were decided locally.
// Functional notes
// RULE1: speed change only for single-axis motion
// RULE2: ramp to new speed over given time
// RULE3: reject speed change lacking remaining pulses
// RULE4: both stop commands drive speed to zero
// RULE5: host fixes speed range before changing
// RULE6: unfixed range caps speed at start peak
// RULE7: comparator change waits for comparator hit
// RULE8: host avoids changes while ramping
// RULE9: target change only in absolute preset
// RULE10: reject target change once decelerating
// RULE11: reject target nearer than half peak*decel
// RULE12: global axis is board*4 plus index
// RULE13: rejections leave sticky readable error bits
`timescale 1ns/1ps
`include "mol_defines.svh"
module mol_axis import mol_pkg::*; #(
  parameter logic [1:0] AXIS_INDEX = 2'h0,
  parameter int TICK_CYCLES = `MOL_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] board_id_switch,
  input wire logic cmp_hit,
  output logic pulse_out,
  output logic dir_out
);
  mol_axis_st_t st_ff, nxt_st;
  logic acc_first, wr_done, tick, preset, cmp_rise, vchg, p_req, start_req;
  logic v_bad_mode, v_short, v_ok, p_bad_mode, p_in_dec, p_near, p_ok;
  logic div_done, carry;
  logic [3:0] cmd;
  logic [5:0] err_set, err_clr, axis_no;
  logic [31:0] rem, limit, vnew, start_pk, start_tgt, pdiff, pabs, floor_v, step;
  logic [31:0] div_quo, rd_data, frac_sum;
  logic [39:0] need;
  logic start_dir;

  function automatic logic [31:0] mol_min(logic [31:0] a, logic [31:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [31:0] mol_absdiff(logic [31:0] a, logic [31:0] b);
    return (a > b) ? a - b : b - a;
  endfunction

  // Pulses covered while speed v falls linearly to zero over t ticks
  function automatic logic [39:0] mol_dist(logic [31:0] v, logic [23:0] t);
    logic [55:0] p;
    p = v * t;
    return {1'b0, p[55:17]};
  endfunction

  function automatic logic [31:0] mol_step_to(logic [31:0] v, logic [31:0] g,
                                              logic [31:0] s);
    if (v < g) begin
      return (g - v <= s) ? g : v + s;
    end
    return (v - g <= s) ? g : v - s;
  endfunction

  function automatic mol_axis_st_t mol_launch(mol_axis_st_t s, logic [31:0] num,
                                              logic [23:0] den, mol_phase_t nx,
                                              logic [31:0] goal);
    s.div_go = 1'b1;
    s.div_num = num;
    s.div_den = (den == 24'h0) ? 24'h1 : den;
    s.after = nx;
    s.vgoal = goal;
    s.phase = MOL_SOLVE;
    return s;
  endfunction

  mol_div i_mol_div (
    .clk(clk),
    .rst_b(rst_b),
    .start(st_ff.div_go),
    .dividend(st_ff.div_num),
    .divisor(st_ff.div_den),
    .done(div_done),
    .quotient(div_quo)
  );

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign pulse_out = st_ff.pulse;
  assign dir_out = st_ff.dir;

  // Writes act at the edge that completes the transfer, reads load one edge earlier
  assign acc_first = psel & penable & ~st_ff.pready;
  assign wr_done = psel & penable & st_ff.pready & pwrite;
  assign cmd = (wr_done && paddr == `MOL_OFS_CMD) ? pwdata[3:0] : 4'h0;
  assign tick = st_ff.tick_cnt == 16'h0;
  assign preset = st_ff.mode != MOL_MODE_VEL;
  assign rem = st_ff.dir ? st_ff.pos - st_ff.target : st_ff.target - st_ff.pos;
  assign limit = st_ff.range_fixed ? st_ff.range : st_ff.start_peak; // see RULE6
  assign vnew = mol_min(st_ff.req_vel, limit); // see RULE6
  assign start_pk = mol_min(st_ff.peak_cfg, st_ff.range_fixed ? st_ff.range : `MOL_VEL_MAX);
  assign start_tgt = (cmd == `MOL_CMD_START_ABS) ? st_ff.move_arg : st_ff.pos + st_ff.move_arg;
  assign start_dir = (cmd == `MOL_CMD_START_VEL) ? st_ff.move_arg[31] :
                     ($signed(start_tgt) < $signed(st_ff.pos));
  assign start_req = cmd inside {`MOL_CMD_START_VEL, `MOL_CMD_START_REL, `MOL_CMD_START_ABS};
  assign cmp_rise = cmp_hit & ~st_ff.cmp_prev;
  assign vchg = (cmd == `MOL_CMD_V_CHANGE) | (st_ff.cmp_armed & cmp_rise); // see RULE7
  assign need = mol_dist(32'(st_ff.vel + vnew), st_ff.req_t) + mol_dist(vnew, st_ff.dec_t);
  assign v_bad_mode = (st_ff.phase inside {MOL_IDLE, MOL_SOLVE, MOL_DECEL}) | st_ff.stopping;
  assign v_short = preset & (rem[31] | (need > {8'h0, rem})); // see RULE3
  assign v_ok = ~st_ff.linked & ~v_bad_mode & ~v_short; // see RULE1
  assign p_req = cmd == `MOL_CMD_P_CHANGE;
  assign p_bad_mode = (st_ff.mode != MOL_MODE_ABS) | (st_ff.phase inside {MOL_IDLE, MOL_SOLVE});
  assign p_in_dec = (st_ff.phase == MOL_DECEL) | st_ff.stopping; // see RULE10
  assign pdiff = st_ff.req_tgt - st_ff.pos;
  assign pabs = pdiff[31] ? 32'h0 - pdiff : pdiff;
  assign p_near = {8'h0, pabs} < mol_dist(st_ff.peak, st_ff.dec_t); // see RULE11
  assign p_ok = ~st_ff.linked & ~p_bad_mode & ~p_in_dec & ~p_near; // see RULE9
  // A rejected request reports why and changes nothing else, except that a rejected comparator change still clears cmp_armed
  assign err_set[`MOL_ERR_SINGLE] = (vchg | p_req) & st_ff.linked; // see RULE13
  assign err_set[`MOL_ERR_MODE] = ~st_ff.linked & (vchg & v_bad_mode | p_req & p_bad_mode);
  assign err_set[`MOL_ERR_PULSES] = vchg & v_short & ~st_ff.linked & ~v_bad_mode;
  assign err_set[`MOL_ERR_DECEL] = p_req & p_in_dec & ~st_ff.linked & ~p_bad_mode;
  assign err_set[`MOL_ERR_NEAR] = p_req & p_near & ~st_ff.linked & ~p_bad_mode & ~p_in_dec;
  assign err_set[`MOL_ERR_BUSY] = start_req & (st_ff.phase != MOL_IDLE);
  assign err_clr = (wr_done && paddr == `MOL_OFS_ERR) ? pwdata[5:0] : 6'h0;
  assign axis_no = {st_ff.board, AXIS_INDEX}; // see RULE12
  assign floor_v = st_ff.stopping ? 32'h0 :
                   (st_ff.init_vel == 32'h0) ? `MOL_VEL_CREEP : st_ff.init_vel;
  // S-curve softens the last part of a ramp, so that ramp runs slightly long
  assign step = (st_ff.scurve && mol_absdiff(st_ff.vel, st_ff.vgoal) <= {st_ff.rate[28:0], 3'h0})
                ? {1'b0, st_ff.rate[31:1]} | 32'h1 : st_ff.rate;
  assign frac_sum = {16'h0, st_ff.frac} + st_ff.vel;
  assign carry = frac_sum[16];

  always_comb begin
    rd_data = 32'h0;
    case (paddr)
      `MOL_OFS_CTRL: rd_data = {30'h0, st_ff.linked, st_ff.scurve};
      `MOL_OFS_INIT_VEL: rd_data = st_ff.init_vel;
      `MOL_OFS_PEAK_VEL: rd_data = st_ff.peak_cfg;
      `MOL_OFS_ACC_TIME: rd_data = {8'h0, st_ff.acc_t};
      `MOL_OFS_DEC_TIME: rd_data = {8'h0, st_ff.dec_t};
      `MOL_OFS_MOVE_ARG: rd_data = st_ff.move_arg;
      `MOL_OFS_REQ_VEL: rd_data = st_ff.req_vel;
      `MOL_OFS_REQ_TIME: rd_data = {8'h0, st_ff.req_t};
      `MOL_OFS_REQ_TARGET: rd_data = st_ff.req_tgt;
      `MOL_OFS_RANGE: rd_data = st_ff.range;
      `MOL_OFS_STATUS: rd_data = {21'h0, st_ff.phase, 3'h0, st_ff.dir, st_ff.range_fixed,
                                  st_ff.cmp_armed, st_ff.stopping, st_ff.phase != MOL_IDLE};
      `MOL_OFS_ERR: rd_data = {26'h0, st_ff.err}; // see RULE13
      `MOL_OFS_POSITION: rd_data = st_ff.pos;
      `MOL_OFS_CUR_VEL: rd_data = st_ff.vel;
      `MOL_OFS_AXIS_ID: rd_data = {24'h0, st_ff.board < `MOL_BOARD_MAX, 1'b0, axis_no};
      default: rd_data = 32'h0;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pulse = 1'b0;
    nxt_st.div_go = 1'b0;
    nxt_st.cmp_prev = cmp_hit;
    nxt_st.tick_cnt = tick ? 16'(TICK_CYCLES - 1) : st_ff.tick_cnt - 16'h1;
    // Switch is caught once after reset so a moving switch cannot renumber the axis
    if (!st_ff.board_taken) begin
      nxt_st.board = board_id_switch;
      nxt_st.board_taken = 1'b1;
    end
    nxt_st.pready = acc_first;
    if (acc_first) begin
      nxt_st.pslverr = (paddr[1:0] != 2'h0) || (paddr > `MOL_OFS_AXIS_ID);
      nxt_st.prdata = pwrite ? 32'h0 : rd_data;
    end
    nxt_st.err = (st_ff.err & ~err_clr) | err_set; // see RULE13
    if (wr_done) begin
      case (paddr)
        `MOL_OFS_CTRL: begin
          nxt_st.scurve = pwdata[`MOL_CTRL_SCURVE];
          nxt_st.linked = pwdata[`MOL_CTRL_LINKED];
        end
        `MOL_OFS_INIT_VEL: nxt_st.init_vel = pwdata;
        `MOL_OFS_PEAK_VEL: nxt_st.peak_cfg = pwdata;
        `MOL_OFS_ACC_TIME: nxt_st.acc_t = pwdata[23:0];
        `MOL_OFS_DEC_TIME: nxt_st.dec_t = pwdata[23:0];
        `MOL_OFS_MOVE_ARG: nxt_st.move_arg = pwdata;
        `MOL_OFS_REQ_VEL: nxt_st.req_vel = pwdata;
        `MOL_OFS_REQ_TIME: nxt_st.req_t = pwdata[23:0];
        `MOL_OFS_REQ_TARGET: nxt_st.req_tgt = pwdata;
        `MOL_OFS_RANGE: nxt_st.range = pwdata;
        default: ;
      endcase
    end
    if (div_done && st_ff.phase == MOL_SOLVE) begin
      nxt_st.rate = (div_quo == 32'h0) ? 32'h1 : div_quo;
      nxt_st.phase = st_ff.after;
    end
    if (tick && st_ff.phase != MOL_IDLE) begin
      if (st_ff.phase == MOL_RAMP) begin
        nxt_st.vel = mol_step_to(st_ff.vel, st_ff.vgoal, step); // see RULE2
        if (nxt_st.vel == st_ff.vgoal) begin
          nxt_st.phase = MOL_CRUISE;
        end
      end else if (st_ff.phase == MOL_DECEL) begin
        nxt_st.vel = (st_ff.vel > floor_v + st_ff.rate) ? st_ff.vel - st_ff.rate : floor_v;
      end
      nxt_st.frac = frac_sum[15:0];
      // No pulse once the target is reached, so a fast profile cannot overshoot by one
      if (carry && !(preset && rem == 32'h0)) begin
        nxt_st.pulse = 1'b1;
        nxt_st.pos = st_ff.dir ? st_ff.pos - 32'h1 : st_ff.pos + 32'h1;
      end
      if (preset && !st_ff.stopping && (st_ff.phase inside {MOL_RAMP, MOL_CRUISE}) &&
          (rem[31] || {8'h0, rem} <= mol_dist(st_ff.vel, st_ff.dec_t))) begin
        nxt_st = mol_launch(nxt_st, st_ff.vel, st_ff.dec_t, MOL_DECEL, 32'h0);
      end
      // A target moved behind the axis slows it to floor_v first, then runs back
      // Reversal waits for a tick without a pulse, so pulse and direction stay paired
      if (preset && !st_ff.stopping && st_ff.phase == MOL_DECEL && rem[31] &&
          st_ff.vel <= floor_v && !carry) begin
        nxt_st.dir = ~st_ff.dir;
        nxt_st = mol_launch(nxt_st, mol_absdiff(st_ff.peak, st_ff.vel), st_ff.acc_t,
                            MOL_RAMP, st_ff.peak);
      end
      if ((preset && rem == 32'h0) ||
          (st_ff.stopping && st_ff.phase == MOL_DECEL && st_ff.vel == 32'h0)) begin
        nxt_st.phase = MOL_IDLE;
        nxt_st.vel = 32'h0;
        nxt_st.stopping = 1'b0;
        nxt_st.cmp_armed = 1'b0;
      end
    end
    if (start_req && st_ff.phase == MOL_IDLE) begin
      nxt_st.mode = (cmd == `MOL_CMD_START_VEL) ? MOL_MODE_VEL :
                    (cmd == `MOL_CMD_START_REL) ? MOL_MODE_REL : MOL_MODE_ABS;
      nxt_st.start_peak = start_pk;
      nxt_st.peak = start_pk;
      nxt_st.vel = mol_min(st_ff.init_vel, start_pk);
      nxt_st.target = start_tgt;
      nxt_st.dir = start_dir;
      nxt_st.stopping = 1'b0;
      nxt_st.frac = 16'h0;
      nxt_st = mol_launch(nxt_st, mol_absdiff(start_pk, nxt_st.vel), st_ff.acc_t,
                          MOL_RAMP, start_pk);
    end
    if (cmd == `MOL_CMD_CMP_V_CHANGE) begin
      nxt_st.cmp_armed = 1'b1;
    end else if (st_ff.cmp_armed && cmp_rise) begin
      nxt_st.cmp_armed = 1'b0;
    end
    if (vchg && v_ok) begin
      nxt_st.peak = vnew;
      nxt_st = mol_launch(nxt_st, mol_absdiff(vnew, st_ff.vel), st_ff.req_t, MOL_RAMP, vnew);
    end
    if (p_req && p_ok) begin
      nxt_st.target = st_ff.req_tgt; // see RULE9
    end
    if (cmd == `MOL_CMD_FIX_RANGE) begin
      nxt_st.range_fixed = 1'b1;
    end else if (cmd == `MOL_CMD_UNFIX_RANGE) begin
      nxt_st.range_fixed = 1'b0;
    end
    if (cmd == `MOL_CMD_RAMP_STOP && st_ff.phase != MOL_IDLE) begin
      nxt_st.stopping = 1'b1; // see RULE4
      nxt_st.cmp_armed = 1'b0;
      nxt_st = mol_launch(nxt_st, st_ff.vel, st_ff.dec_t, MOL_DECEL, 32'h0);
    end
    if (cmd == `MOL_CMD_EMG_STOP) begin
      nxt_st.phase = MOL_IDLE; // see RULE4
      nxt_st.vel = 32'h0;
      nxt_st.stopping = 1'b0;
      nxt_st.cmp_armed = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
      st_ff.init_vel <= `MOL_RST_INIT_VEL;
      st_ff.peak_cfg <= `MOL_RST_PEAK_VEL;
      st_ff.acc_t <= `MOL_RST_ACC_TIME;
      st_ff.dec_t <= `MOL_RST_DEC_TIME;
      st_ff.range <= `MOL_RST_RANGE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_single_only: assert property (vchg && st_ff.linked |=> // see RULE1
    $stable(st_ff.peak) && st_ff.err[`MOL_ERR_SINGLE]) else $error("Linked speed change taken");
  a_ramp_goal: assert property (vchg && v_ok |=> // see RULE2
    st_ff.phase == MOL_SOLVE && st_ff.vgoal == $past(vnew) ##[30:40] st_ff.phase != MOL_SOLVE)
    else $error("Speed change did not start its ramp");
  a_short_rej: assert property (vchg && v_short && !st_ff.linked && !v_bad_mode |=> // see RULE3
    $stable(st_ff.peak) && st_ff.err[`MOL_ERR_PULSES]) else $error("Short speed change taken");
  a_emg_zero: assert property (cmd == `MOL_CMD_EMG_STOP |=> // see RULE4
    st_ff.vel == 32'h0 && st_ff.phase == MOL_IDLE) else $error("Emergency stop left speed");
  a_stop_fall: assert property (st_ff.stopping && st_ff.phase != MOL_IDLE |-> // see RULE4
    st_ff.vgoal == 32'h0 ##1 st_ff.vel <= $past(st_ff.vel)) else $error("Stop raised speed");
  a_range_cap: assert property (vchg && v_ok && !st_ff.range_fixed |=> // see RULE6
    st_ff.peak <= st_ff.start_peak) else $error("Unfixed range exceeded");
  a_cmp_wait: assert property (st_ff.cmp_armed && !cmp_rise && cmd == 4'h0 |=> // see RULE7
    $stable(st_ff.peak)) else $error("Comparator change applied early");
  a_abs_only: assert property (p_req && st_ff.mode != MOL_MODE_ABS |=> // see RULE9
    $stable(st_ff.target)) else $error("Target change outside absolute move");
  a_dec_rej: assert property (p_req && p_in_dec |=> // see RULE10
    $stable(st_ff.target)) else $error("Target change taken while decelerating");
  a_near_rej: assert property (p_req && p_near |=> // see RULE11
    $stable(st_ff.target)) else $error("Target too near taken");
  a_axis_num: assert property (acc_first && !pwrite && paddr == `MOL_OFS_AXIS_ID |=> // see RULE12
    st_ff.prdata[5:0] == 6'(st_ff.board * 4 + AXIS_INDEX)) else $error("Axis number wrong");
  a_err_keep: assert property (st_ff.err[`MOL_ERR_NEAR] && err_clr == 6'h0 |=> // see RULE13
    st_ff.err[`MOL_ERR_NEAR]) else $error("Error bit lost");
  a_stop_goal: assert property (cmd == `MOL_CMD_RAMP_STOP && st_ff.phase != MOL_IDLE // see RULE4
    |=> st_ff.stopping && st_ff.vgoal == 32'h0) else $error("Ramp stop aimed above zero");
  a_idle_quiet: assert property (st_ff.pulse |-> $past(st_ff.phase) != MOL_IDLE) // see RULE4
    else $error("Pulse while stopped");
  a_cmp_fire: assert property (st_ff.cmp_armed && cmp_rise && v_ok && cmd == 4'h0 |=> // see RULE7
    st_ff.phase == MOL_SOLVE && !st_ff.cmp_armed) else $error("Comparator change not applied");
  a_decel_err: assert property (p_req && p_in_dec && !st_ff.linked && !p_bad_mode |=> // see RULE10
    st_ff.err[`MOL_ERR_DECEL]) else $error("Decel target change not flagged");
  a_tgt_taken: assert property (p_req && p_ok |=> // see RULE9
    st_ff.target == $past(st_ff.req_tgt)) else $error("Accepted target not applied");
endmodule

// *** mol_motor_model.sv ***
/*
  Behavioural stepper driver for the motion override bench: counts step
  pulses, signed by the direction level.
  Assumes one-cycle pulses from the axis and a shared clock and reset.
*/
`timescale 1ns/1ps
module mol_motor_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic pulse_out,
  input wire logic dir_out,
  output logic [31:0] steps
);
  // Sampled on the clock, so a pulse wider than one cycle would count once per cycle it is high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      steps <= 32'h0000_0000;
    end else if (pulse_out) begin
      steps <= dir_out ? steps - 32'h0000_0001 : steps + 32'h0000_0001;
    end
  end
endmodule

// *** mol_axis_tb.sv ***
/*
  Self-checking bench of one motion override axis: APB master tasks and
  move, override and stop sequences with expected register values.
  Assumes mol_defines.svh offsets and the motor model on the pulse outputs.
*/
`timescale 1ns/1ps
`include "mol_defines.svh"
module mol_axis_tb import mol_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic cmp_hit = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] board_id_switch = 4'h1;
  logic [31:0] prdata, steps, rdata, p0;
  logic pready, pslverr, pulse_out, dir_out, rerr;
  int n_mismatch = 0;
  int check_count = 0;

  always #5 clk = ~clk;

  // Short tick keeps whole moves within a few thousand cycles
  mol_axis #(.AXIS_INDEX(2'h2), .TICK_CYCLES(4)) i_mol_axis (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .board_id_switch(board_id_switch), .cmp_hit(cmp_hit),
    .pulse_out(pulse_out), .dir_out(dir_out));
  mol_motor_model i_mol_motor_model (.clk(clk), .rst_b(rst_b),
    .pulse_out(pulse_out), .dir_out(dir_out), .steps(steps));

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hang(input string what);
    n_mismatch++;
    $display("ERROR %s expected done seen timeout", what);
    stop_test();
  endtask

  // Entered just after a rising edge; the final edge keeps psel from
  // being assigned twice in one time step by back-to-back calls
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) hang("pready");
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic cmd(input logic [3:0] c);
    apb(1'b1, `MOL_OFS_CMD, {28'h0, c});
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdata);
  endtask

  task automatic wait_phase(input logic [2:0] ph);
    int n;
    for (n = 0; n < 3000; n++) begin
      apb(1'b0, `MOL_OFS_STATUS, 32'h0);
      if (rdata[10:8] === ph) return;
    end
    hang("phase");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rchk("peak_vel", `MOL_OFS_PEAK_VEL, `MOL_RST_PEAK_VEL);
    rchk("acc_time", `MOL_OFS_ACC_TIME, {8'h00, `MOL_RST_ACC_TIME});
    rchk("range", `MOL_OFS_RANGE, `MOL_RST_RANGE);
    rchk("axis_id", `MOL_OFS_AXIS_ID, 32'h80 | (32'h4 * board_id_switch + 32'h2));
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    wr(`MOL_OFS_ACC_TIME, 32'h64);
    wr(`MOL_OFS_DEC_TIME, 32'h64);
    wr(`MOL_OFS_REQ_TIME, 32'ha);
    wr(`MOL_OFS_MOVE_ARG, 32'h1);
    // Linked motion refuses overrides
    wr(`MOL_OFS_CTRL, 32'h2);
    cmd(`MOL_CMD_START_VEL);
    wait_phase(3'h3);
    wr(`MOL_OFS_REQ_VEL, 32'h2000);
    cmd(`MOL_CMD_V_CHANGE);
    rchk("err_linked", `MOL_OFS_ERR, 32'h1 << `MOL_ERR_SINGLE);
    cmd(`MOL_CMD_EMG_STOP);
    wait_phase(3'h0);
    rchk("emg_vel", `MOL_OFS_CUR_VEL, 32'h0);
    wr(`MOL_OFS_ERR, 32'h3f);
    wr(`MOL_OFS_CTRL, 32'h0);
    // Velocity mode: cap without range, then real changes
    cmd(`MOL_CMD_UNFIX_RANGE);
    wr(`MOL_OFS_PEAK_VEL, 32'h4000);
    cmd(`MOL_CMD_START_VEL);
    wait_phase(3'h3);
    wr(`MOL_OFS_REQ_VEL, 32'h8000);
    cmd(`MOL_CMD_V_CHANGE);
    wait_phase(3'h3);
    rchk("vel_capped", `MOL_OFS_CUR_VEL, 32'h4000);
    cmd(`MOL_CMD_FIX_RANGE);
    cmd(`MOL_CMD_V_CHANGE);
    wait_phase(3'h3);
    rchk("vel_changed", `MOL_OFS_CUR_VEL, 32'h8000);
    wr(`MOL_OFS_REQ_VEL, 32'h2000);
    cmd(`MOL_CMD_CMP_V_CHANGE);
    repeat (40) @(posedge clk);
    rchk("vel_before_hit", `MOL_OFS_CUR_VEL, 32'h8000);
    cmp_hit <= 1'b1;
    wait_phase(3'h3);
    rchk("vel_after_hit", `MOL_OFS_CUR_VEL, 32'h2000);
    cmp_hit <= 1'b0;
    cmd(`MOL_CMD_RAMP_STOP);
    wait_phase(3'h0);
    rchk("ramp_stop_vel", `MOL_OFS_CUR_VEL, 32'h0);
    // Relative preset: too few pulses for the new speed
    wr(`MOL_OFS_ERR, 32'h3f);
    apb(1'b0, `MOL_OFS_POSITION, 32'h0);
    p0 = rdata;
    wr(`MOL_OFS_PEAK_VEL, 32'h8000);
    wr(`MOL_OFS_MOVE_ARG, 32'd300);
    cmd(`MOL_CMD_START_REL);
    wait_phase(3'h3);
    wr(`MOL_OFS_REQ_VEL, 32'h10000);
    wr(`MOL_OFS_REQ_TIME, 32'h3e8);
    cmd(`MOL_CMD_V_CHANGE);
    rchk("err_pulses", `MOL_OFS_ERR, 32'h1 << `MOL_ERR_PULSES);
    rchk("vel_kept", `MOL_OFS_CUR_VEL, 32'h8000);
    cmd(`MOL_CMD_P_CHANGE);
    rchk("err_mode", `MOL_OFS_ERR, 32'h6);
    wait_phase(3'h0);
    rchk("rel_end", `MOL_OFS_POSITION, p0 + 32'd300);
    chk("motor_rel", p0 + 32'd300, steps);
    wr(`MOL_OFS_ERR, 32'h3f);
    // Absolute preset: stop distance 0x8000*100/2 >> 16 = 25 pulses
    p0 = p0 + 32'd300;
    wr(`MOL_OFS_MOVE_ARG, p0 + 32'd1000);
    wr(`MOL_OFS_CTRL, 32'h1);
    rchk("ctrl_scurve", `MOL_OFS_CTRL, 32'h1);
    cmd(`MOL_CMD_START_ABS);
    wait_phase(3'h3);
    cmd(`MOL_CMD_START_REL);
    rchk("err_busy", `MOL_OFS_ERR, 32'h1 << `MOL_ERR_BUSY);
    wr(`MOL_OFS_ERR, 32'h3f);
    apb(1'b0, `MOL_OFS_POSITION, 32'h0);
    wr(`MOL_OFS_REQ_TARGET, rdata + 32'd10);
    cmd(`MOL_CMD_P_CHANGE);
    rchk("err_near", `MOL_OFS_ERR, 32'h1 << `MOL_ERR_NEAR);
    wr(`MOL_OFS_ERR, 32'h3f);
    wr(`MOL_OFS_REQ_TARGET, p0 + 32'd600);
    cmd(`MOL_CMD_P_CHANGE);
    rchk("err_far", `MOL_OFS_ERR, 32'h0);
    wait_phase(3'h4);
    wr(`MOL_OFS_REQ_TARGET, p0 + 32'd2000);
    cmd(`MOL_CMD_P_CHANGE);
    rchk("err_decel", `MOL_OFS_ERR, 32'h1 << `MOL_ERR_DECEL);
    wait_phase(3'h0);
    rchk("abs_end", `MOL_OFS_POSITION, p0 + 32'd600);
    chk("motor_abs", p0 + 32'd600, steps);
    stop_test();
  end
endmodule
